// File: logic/pts_timer.sv
// Purpose: Eight bit period timer with prescaler, postscaler and AXI4-Lite registers.
// Assumes: One clock; the internal clock is clk_sys_i and a fixed divide by four feeds the timer.
// Notes:   Reading the flag register clears its sticky flag.
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_timer (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             match_pulse_o,
   output logic [7:0]       pwm_count_o,
   output logic             irq_o
);
   logic [7:0]  period_count;
   logic [7:0]  period_limit;
   logic [6:0]  period_timer_control;
   logic        period_event_flag;
   logic        period_event_enable;
   logic [1:0]  quarter;
   logic        aw_held;
   logic        w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic        w_lane0;
   logic        wr_go;
   logic [7:0]  wr_idx;
   logic        wr_hit;
   logic        wr_count;
   logic        wr_control;
   logic        scaler_clr;
   logic        run_control;
   logic        tick_in;
   logic        pre_tick;
   logic        post_wrap;
   logic        match;
   logic        rd_go;
   logic [7:0]  rd_idx;
   logic        rd_flag;
   logic [1:0]  prescale_select;
   logic [3:0]  postscale_select;
   logic [1:0]  pre_last;

   assign run_control      = period_timer_control[`PTS_CTL_RUN_BIT];
   assign prescale_select  = period_timer_control[`PTS_CTL_PRE_LSB +: 2];
   assign postscale_select = period_timer_control[`PTS_CTL_POST_LSB +: 4];

   // Write channel: address and data are latched independently, in either order.
   assign wr_go      = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx     = aw_addr[9:2];
   assign wr_hit     = (aw_addr[31:`PTS_ADDR_W] == '0);
   assign wr_count   = ce_i && wr_go && wr_hit && w_lane0 && (wr_idx == `PTS_IDX_COUNT);
   assign wr_control = ce_i && wr_go && wr_hit && w_lane0 && (wr_idx == `PTS_IDX_CONTROL);
   assign scaler_clr = wr_count || wr_control;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 32'h0000_0000;
         w_data        <= 32'h0000_0000;
         w_lane0       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PTS_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; bit seven of control is not stored and reads zero.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         period_limit         <= `PTS_RST_LIMIT;
         period_timer_control <= `PTS_RST_CONTROL;
         period_event_enable  <= 1'b0;
      end else if (ce_i && wr_go && wr_hit && w_lane0) begin
         if (wr_idx == `PTS_IDX_LIMIT) begin
            period_limit <= w_data[7:0];
         end
         if (wr_idx == `PTS_IDX_CONTROL) begin
            period_timer_control <= w_data[6:0];
         end
         if (wr_idx == `PTS_IDX_ENABLE) begin
            period_event_enable <= w_data[`PTS_FLAG_BIT];
         end
      end
   end

   // Fixed divide by four of the internal clock; held while halted to save power.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || (ce_i && scaler_clr)) begin
         quarter <= 2'h0;
      end else if (ce_i && run_control) begin
         quarter <= 2'(quarter + 1'b1);
      end
   end
   assign tick_in = run_control && (quarter == `PTS_INT_DIV);

   always_comb begin
      case (prescale_select)
         2'h0:    pre_last = 2'h0;
         2'h1:    pre_last = 2'h3;
         default: pre_last = 2'h3;
      endcase
   end

   // Divide by 16 is built as two chained divide by four stages.
   logic pre_a_wrap;
   logic pre_a_step;
   pts_divider #(.W(2)) u_pre_a (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .clr_i     (scaler_clr),
      .step_i    (tick_in && (prescale_select != pts_pkg::PTS_PRE_1)),
      .last_i    (pre_last),
      .wrap_o    (pre_a_wrap)
   );
   assign pre_a_step = pre_a_wrap && prescale_select[1];
   logic pre_b_wrap;
   pts_divider #(.W(2)) u_pre_b (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .clr_i     (scaler_clr),
      .step_i    (pre_a_step),
      .last_i    (2'h3),
      .wrap_o    (pre_b_wrap)
   );
   always_comb begin
      case (prescale_select)
         2'h0:    pre_tick = tick_in;
         2'h1:    pre_tick = pre_a_wrap;
         default: pre_tick = pre_b_wrap;
      endcase
   end

   assign match = pre_tick && (period_count == period_limit);

   // Count register; a control write does not touch it.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         period_count <= `PTS_RST_COUNT;
      end else if (ce_i) begin
         if (wr_count) begin
            period_count <= w_data[7:0];
         end else if (match) begin
            period_count <= 8'h00;
         end else if (pre_tick) begin
            period_count <= 8'(period_count + 1'b1);
         end
      end
   end

   pts_divider #(.W(4)) u_post (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .clr_i     (scaler_clr),
      .step_i    (match),
      .last_i    (postscale_select),
      .wrap_o    (post_wrap)
   );

   // Read channel; a read of the flag register clears the flag.
   assign rd_go   = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = s_axi_araddr[9:2];
   assign rd_flag = ce_i && rd_go && (s_axi_araddr[31:`PTS_ADDR_W] == '0)
                    && (rd_idx == `PTS_IDX_FLAG);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PTS_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PTS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[31:`PTS_ADDR_W] != '0) begin
               s_axi_rresp <= `PTS_RESP_SLVERR;
            end else begin
               case (rd_idx)
                  `PTS_IDX_COUNT:   s_axi_rdata[7:0] <= period_count;
                  `PTS_IDX_CONTROL: s_axi_rdata[7:0] <= {1'b0, period_timer_control};
                  `PTS_IDX_LIMIT:   s_axi_rdata[7:0] <= period_limit;
                  `PTS_IDX_FLAG:    s_axi_rdata[`PTS_FLAG_BIT] <= period_event_flag;
                  `PTS_IDX_ENABLE:  s_axi_rdata[`PTS_FLAG_BIT] <= period_event_enable;
                  default:          s_axi_rresp <= `PTS_RESP_SLVERR;
               endcase
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Sticky flag: a new event in the clearing cycle wins, so none is lost.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         period_event_flag <= 1'b0;
      end else if (ce_i) begin
         if (post_wrap) begin
            period_event_flag <= 1'b1;
         end else if (rd_flag || (wr_go && wr_hit && w_lane0 && wr_idx == `PTS_IDX_FLAG
                                  && !w_data[`PTS_FLAG_BIT])) begin
            period_event_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_o         <= 1'b0;
         match_pulse_o <= 1'b0;
         pwm_count_o   <= 8'h00;
      end else if (ce_i) begin
         irq_o         <= period_event_flag && period_event_enable;
         match_pulse_o <= match;
         pwm_count_o   <= period_count;
      end
   end

   a_count_wraps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && match && !wr_count |=> period_count == 8'h00)
      else $error("Count did not wrap after match.");
   a_halt_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && !run_control && !wr_count |=> $stable(period_count))
      else $error("Count moved while halted.");
   a_ctl_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_control && !pre_tick |=> $stable(period_count))
      else $error("Control write changed count.");
   a_pulse_export: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && match |=> match_pulse_o)
      else $error("Match pulse not exported.");
   a_flag_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && post_wrap |=> period_event_flag)
      else $error("Flag not set by postscaler.");
   a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && !period_event_enable |=> !irq_o)
      else $error("Interrupt raised while disabled.");
   a_post_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      postscale_select == 4'h0 && match |-> post_wrap)
      else $error("Ratio one to one missed.");
   a_pre_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      prescale_select == 2'h0 && tick_in |-> pre_tick)
      else $error("Prescale one missed tick.");
   a_limit_reset: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> period_limit == 8'hFF && period_timer_control == 7'h00)
      else $error("Reset values wrong.");
   a_count_reset: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> period_count == 8'h00)
      else $error("Count not cleared by reset.");
   a_no_tick_clr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && scaler_clr |=> quarter == 2'h0)
      else $error("Scaler not cleared by write.");
   // Second count of matches, kept apart from the divider so a broken divider cannot hide.
   logic [4:0] chk_matches;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || (ce_i && scaler_clr)) begin
         chk_matches <= 5'h00;
      end else if (ce_i && match) begin
         chk_matches <= post_wrap ? 5'h00 : 5'(chk_matches + 1'b1);
      end
   end
   a_post_ratio: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && match |-> post_wrap == (chk_matches == {1'b0, postscale_select}))
      else $error("Postscaler ratio wrong.");
   a_run_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !run_control |-> !pre_tick)
      else $error("Tick while halted.");
   a_pwm_base: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i |=> pwm_count_o == $past(period_count))
      else $error("PWM count not following.");
endmodule : pts_timer

// File: logic/pts_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the period timer.
// Assumes: AXI4-Lite data path of 32 bits, one register to an aligned word.
// Notes:   Register offsets are all multiples of four, so each is a word index.
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
`define PTS_IDX_COUNT      8'h11
`define PTS_IDX_CONTROL    8'h12
`define PTS_IDX_LIMIT      8'h92
`define PTS_IDX_FLAG       8'h0C
`define PTS_IDX_ENABLE     8'h8C
`define PTS_ADDR_W         10
`define PTS_RST_COUNT      8'h00
`define PTS_RST_CONTROL    7'h00
`define PTS_RST_LIMIT      8'hFF
`define PTS_CTL_PRE_LSB    0
`define PTS_CTL_RUN_BIT    2
`define PTS_CTL_POST_LSB   3
`define PTS_FLAG_BIT       1
`define PTS_INT_DIV        2'h3
`define PTS_RESP_OKAY      2'h0
`define PTS_RESP_SLVERR    2'h2
`endif

// File: logic/pts_pkg.sv
// Purpose: Types shared by the period timer files.
// Assumes: Nothing beyond the constants header.
// Notes:   Prescale selection is a small enumeration.
package pts_pkg;
   typedef enum logic [1:0] {
      PTS_PRE_1  = 2'h0,
      PTS_PRE_4  = 2'h1,
      PTS_PRE_16 = 2'h2
   } pts_pre_t;
endpackage : pts_pkg

// File: logic/pts_divider.sv
// Purpose: Generic modulo counter that pulses when it wraps.
// Assumes: Synchronous clear and enable; clear wins over count.
// Notes:   Used for the prescaler and the postscaler.
`timescale 1ns/1ps
module pts_divider #(
   parameter int W = 4
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   input  wire logic         clr_i,
   input  wire logic         step_i,
   input  wire logic [W-1:0] last_i,
   output logic              wrap_o
);
   logic [W-1:0] cnt;

   assign wrap_o = step_i && (cnt == last_i);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || (ce_i && clr_i)) begin
         cnt <= '0;
      end else if (ce_i && step_i) begin
         cnt <= (cnt == last_i) ? '0 : W'(cnt + 1'b1);
      end
   end
endmodule : pts_divider

// File: bench/pts_timer_test.sv
// Purpose: Self-checking bench for the period timer and its AXI4-Lite registers.
// Assumes: Answers come within 200 cycles; the bench waits on handshakes and counts a longer wait as a mismatch.
// Notes:   Periods are measured between match pulses, so the first tick phase does not matter.
`timescale 1ns/1ps
`include "pts_params.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module pts_timer_test;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic        ce_i      = 1'b1;
   logic [31:0] awaddr    = 32'h0;
   logic        awvalid   = 1'b0;
   logic        awready;
   logic [31:0] wdata     = 32'h0;
   logic        wvalid    = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready    = 1'b0;
   logic [31:0] araddr    = 32'h0;
   logic        arvalid   = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready    = 1'b0;
   logic        match_pulse_o;
   logic [7:0]  pwm_count_o;
   logic        irq_o;
   int          miscompares = 0;
   int          total_checks = 0;
   int          seed = 63608;
   logic [31:0] rd;
   logic [1:0]  rs;
   logic [1:0]  bs;
   logic [7:0]  v;
   logic [3:0]  ps;
   int          c;
   always #20 clk_sys_i = ~clk_sys_i;
   pts_timer pts_timer_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .match_pulse_o(match_pulse_o), .pwm_count_o(pwm_count_o), .irq_o(irq_o));
   function automatic logic [31:0] ba(input logic [7:0] idx);
      return {22'h0, idx, 2'h0};
   endfunction : ba
   function automatic int exp_period(input logic [1:0] pre, input logic [7:0] lim);
      int dv;
      dv = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
      return 4 * dv * (int'(lim) + 1);
   endfunction : exp_period
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 200);
      bs = bresp;
      bready <= 1'b0;
      if (n >= 200) miscompares++;
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 200) miscompares++;
   endtask : axr
   task automatic wait_pulse(output int cyc);
      cyc = 0;
      do begin
         @(posedge clk_sys_i);
         cyc++;
      end while (!match_pulse_o && cyc < 5000);
   endtask : wait_pulse
   // The enable register gates only the interrupt line, never the flag itself.
   task automatic post_test(input logic [3:0] n, input logic en);
      int p;
      int k;
      p = 0;
      axw(ba(`PTS_IDX_CONTROL), 32'h0);
      axw(ba(`PTS_IDX_COUNT), 32'h0);
      axr(ba(`PTS_IDX_FLAG), rd, rs);
      axw(ba(`PTS_IDX_ENABLE), {30'h0, en, 1'b0});
      axw(ba(`PTS_IDX_LIMIT), 32'h1);
      axw(ba(`PTS_IDX_CONTROL), {25'h0, n, 3'h4});
      for (k = 0; k < 3000 && !(en ? irq_o : p == int'(n) + 1); k++) begin
         @(posedge clk_sys_i);
         if (match_pulse_o) p++;
      end
      if (en) `CHK("matches to flag", int'(n) + 1, p)
      repeat (3) @(posedge clk_sys_i);
      `CHK("irq level", en, irq_o)
      axw(ba(`PTS_IDX_CONTROL), 32'h0);
      axr(ba(`PTS_IDX_FLAG), rd, rs);
      `CHK("flag set", 1'b1, rd[`PTS_FLAG_BIT])
      axr(ba(`PTS_IDX_FLAG), rd, rs);
      `CHK("flag cleared", 1'b0, rd[`PTS_FLAG_BIT])
      `CHK("irq dropped", 1'b0, irq_o)
   endtask : post_test
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   initial begin
      #(40 * 80000);
      miscompares++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      axr(ba(`PTS_IDX_COUNT), rd, rs);
      `CHK("count reset", 32'h0, rd)
      axr(ba(`PTS_IDX_CONTROL), rd, rs);
      `CHK("control reset", 32'h0, rd)
      axr(ba(`PTS_IDX_LIMIT), rd, rs);
      `CHK("limit reset", 32'hFF, rd)
      $display("test reset values done");
      v = 8'($random(seed));
      axw(ba(`PTS_IDX_LIMIT), {24'h0, v});
      axr(ba(`PTS_IDX_LIMIT), rd, rs);
      `CHK("limit rw", {24'h0, v}, rd)
      axw(ba(`PTS_IDX_CONTROL), 32'hFB);
      axr(ba(`PTS_IDX_CONTROL), rd, rs);
      `CHK("control bit7", 32'h7B, rd)
      axw(ba(`PTS_IDX_COUNT), 32'h37);
      axw(ba(`PTS_IDX_CONTROL), 32'h01);
      axr(ba(`PTS_IDX_COUNT), rd, rs);
      `CHK("count kept", 32'h37, rd)
      `CHK("pwm count", 8'h37, pwm_count_o)
      axr(32'h100, rd, rs);
      `CHK("unmapped resp", `PTS_RESP_SLVERR, rs)
      $display("test register access done");
      for (int pre = 0; pre < 4; pre++) begin
         v = 8'($random(seed) & 32'h7);
         if (pre == 0) v = 8'h0;
         axw(ba(`PTS_IDX_LIMIT), {24'h0, v});
         axw(ba(`PTS_IDX_COUNT), 32'h0);
         axw(ba(`PTS_IDX_CONTROL), {30'h1, 2'(pre)});
         wait_pulse(c);
         wait_pulse(c);
         `CHK("period cycles", exp_period(2'(pre), v), c)
         wait_pulse(c);
         `CHK("period again", exp_period(2'(pre), v), c)
      end
      $display("test periods done");
      axw(ba(`PTS_IDX_CONTROL), 32'h0);
      axr(ba(`PTS_IDX_COUNT), rd, rs);
      v = rd[7:0];
      repeat (100) @(posedge clk_sys_i);
      axr(ba(`PTS_IDX_COUNT), rd, rs);
      `CHK("halted count", {24'h0, v}, rd)
      $display("test halt done");
      axw(ba(`PTS_IDX_LIMIT), 32'hFF);
      axw(ba(`PTS_IDX_CONTROL), 32'h04);
      repeat (8) @(posedge clk_sys_i);
      ce_i <= 1'b0;
      @(posedge clk_sys_i);
      v = pwm_count_o;
      repeat (50) @(posedge clk_sys_i);
      `CHK("frozen count", v, pwm_count_o)
      ce_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      `CHK("count resumed", 1'b1, pwm_count_o !== v)
      axw(ba(`PTS_IDX_LIMIT), 32'h5A);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      axr(ba(`PTS_IDX_LIMIT), rd, rs);
      `CHK("limit after reset", 32'hFF, rd)
      axr(ba(`PTS_IDX_COUNT), rd, rs);
      `CHK("count after reset", 32'h0, rd)
      axr(ba(`PTS_IDX_CONTROL), rd, rs);
      `CHK("control after reset", 32'h0, rd)
      $display("test freeze and reset done");
      post_test(4'h0, 1'b0);
      post_test(4'hF, 1'b1);
      ps = 4'($random(seed));
      post_test(ps, 1'b1);
      axw(ba(`PTS_IDX_CONTROL), 32'h04);
      repeat (20) @(posedge clk_sys_i);
      axw(ba(`PTS_IDX_CONTROL), 32'h0);
      `CHK("irq before clear", 1'b1, irq_o)
      axw(ba(`PTS_IDX_FLAG), 32'h0);
      `CHK("write resp", `PTS_RESP_OKAY, bs)
      axr(ba(`PTS_IDX_FLAG), rd, rs);
      `CHK("flag write clear", 32'h0, rd)
      axr(ba(`PTS_IDX_ENABLE), rd, rs);
      `CHK("enable readback", 32'h2, rd)
      axw(32'h400, 32'h0);
      `CHK("bad write resp", `PTS_RESP_SLVERR, bs)
      $display("test postscale done");
      results();
   end
endmodule : pts_timer_test
